// [hdl/nvm_pkg.sv]
`default_nettype none
package nvm_pkg;

  // ==========================================================
  // Register indices (byte address is four times the index)
  localparam logic [11:0] CTRL_INDEX       = 12'hFA6;
  localparam logic [11:0] UNLOCK_INDEX     = 12'hFA7;
  localparam logic [11:0] DATA_INDEX       = 12'hFA8;
  localparam logic [11:0] ADDR_INDEX       = 12'hFA9;
  localparam logic [11:0] IRQ_STATUS_INDEX = 12'hFAA;
  localparam logic [11:0] IRQ_MASK_INDEX   = 12'hFAB;

  // ==========================================================
  // Control register fields
  localparam int BIT_FLASH_SEL = 7;
  localparam int BIT_CFG_SEL   = 6;
  localparam int BIT_ROW_ERASE = 4;
  localparam int BIT_FAULT     = 3;
  localparam int BIT_ALLOW     = 2;
  localparam int BIT_WSTART    = 1;
  localparam int BIT_RSTART    = 0;
  localparam logic [7:0] BYTE_ZERO = 8'h00;

  // ==========================================================
  // Interrupt status and mask fields
  localparam int IRQ_W     = 2;
  localparam int IRQ_DONE  = 0;
  localparam int IRQ_FAULT = 1;
  localparam logic [IRQ_W-1:0] IRQ_RESET = 2'h0;

  // ==========================================================
  // Self-timed write or erase duration
  localparam int CLK_PERIOD_NS = 100;
  localparam int WRITE_TIME_NS = 20000;
  localparam int WRITE_CYCLES  = WRITE_TIME_NS / CLK_PERIOD_NS;
  localparam int TIMER_W       = 8;

  // ==========================================================
  // Types
  typedef enum logic [1:0] {SPACE_EEPROM, SPACE_FLASH, SPACE_CONFIG} space_t;

  typedef struct packed {
    logic        read;
    logic        write;
    logic        erase;
    space_t      space;
    logic [7:0]  addr;
    logic [7:0]  data;
    logic [21:0] tbl_ptr;
  } nvm_cmd_t;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic        mapped;
    logic [11:0] index;
  } bus_req_t;

  // Target memory from the two select bits; config wins over flash
  function automatic space_t target_space(input logic flash, input logic cfg);
    if (cfg) begin
      return SPACE_CONFIG;
    end
    return flash ? SPACE_FLASH : SPACE_EEPROM;
  endfunction : target_space

endpackage : nvm_pkg
`default_nettype wire

// [hdl/nvm_op_timer.sv]
`timescale 1ns/1ps
`default_nettype none
module nvm_op_timer
  import nvm_pkg::*;
(
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic start,
  input  wire logic abort,
  output var  logic busy,
  output var  logic done
);

  localparam logic [TIMER_W-1:0] LAST = TIMER_W'(WRITE_CYCLES - 1);

  logic [TIMER_W-1:0] count;

  // ==========================================================
  // Cycle counter; abort beats start so a reset cuts the run
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      busy  <= 1'b0;
      done  <= 1'b0;
      count <= '0;
    end else if (abort) begin
      busy  <= 1'b0;
      done  <= 1'b0;
      count <= '0;
    end else if (start && !busy) begin
      busy  <= 1'b1;
      done  <= 1'b0;
      count <= '0;
    end else begin
      done  <= busy && (count == LAST);
      busy  <= busy && (count != LAST);
      count <= busy ? count + 1'b1 : '0;
    end
  end

endmodule : nvm_op_timer
`default_nettype wire

// [hdl/nvm_access_control.sv]
// The AHB-Lite register port was decided locally.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - The unlock port stores nothing and always reads back as zero.
// - The unlock port is not needed by the write and erase sequences and steers nothing.
// - Control bit 7 targets program flash when one and data EEPROM when zero.
// - Control bit 6 set targets configuration space regardless of bit 7.
// - With row-erase select set and program flash targeted, write-start erases the row at the table pointer.
// - Writes and erases need the write-allow bit, which is clear after power-up.
// - A master-clear or watchdog reset that cuts a running write sets the fault bit.
// - Data and address registers return to zero on reset, so retries must reload them.
// - Write-start can only be set by software and is cleared by hardware at completion.
// - Completion sets a done flag that stays until software clears it.
// - Read-start runs a one-cycle read of EEPROM, or of configuration space when bit 6 is set, then clears, and is refused while flash is selected.
module nvm_access_control
  import nvm_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output var  logic [31:0] hrdata,
  output var  logic        hreadyout,
  output var  logic        hresp,
  input  wire logic        master_clear_pin_n,
  input  wire logic        watchdog_timeout,
  input  wire logic [21:0] table_pointer,
  input  wire logic [7:0]  nvm_read_data,
  output var  nvm_cmd_t    nvm_cmd,
  output var  logic        nvm_busy,
  output var  logic        nvm_irq
);

  // ==========================================================
  // State
  bus_req_t         req;
  logic             flash_space_select;
  logic             config_space_select;
  logic             row_erase_select;
  logic             program_fault;
  logic             program_allow;
  logic             write_start;
  logic             read_start;
  logic [7:0]       nvm_data_reg;
  logic [7:0]       nvm_addr_reg;
  logic [IRQ_W-1:0] irq_status;
  logic [IRQ_W-1:0] irq_mask;
  logic             timer_busy;
  logic             timer_done;

  // ==========================================================
  // Bus decode
  wire logic        accept   = hsel && htrans[1] && hready;
  wire logic        hit_low  = (haddr[31:14] == 18'h0);
  wire logic        wr_do    = req.valid && req.write && hreadyout;
  wire logic        rd_do    = req.valid && !req.write && !hreadyout;
  wire logic        wr_map   = wr_do && req.mapped;
  wire logic        wr_ctrl  = wr_map && (req.index == CTRL_INDEX);
  wire logic        wr_data  = wr_map && (req.index == DATA_INDEX);
  wire logic        wr_addr  = wr_map && (req.index == ADDR_INDEX);
  wire logic        wr_mask  = wr_map && (req.index == IRQ_MASK_INDEX);
  wire logic        wr_unlk  = wr_map && (req.index == UNLOCK_INDEX);
  wire logic        rd_stat  = rd_do && req.mapped && (req.index == IRQ_STATUS_INDEX);
  wire logic [7:0]  wbyte    = hwdata[7:0];

  // Master-clear or watchdog reset of the core, seen as a warm clear
  wire logic        warm     = !master_clear_pin_n || watchdog_timeout;

  // ==========================================================
  // Control register image; bit 5 is tied low
  // bit five zero
  wire logic [7:0] ctrl_image = {flash_space_select, config_space_select, 1'b0,
                                 row_erase_select, program_fault, program_allow,
                                 write_start, read_start};

  wire logic [7:0] rd_byte =
    !req.mapped                        ? BYTE_ZERO :
    (req.index == CTRL_INDEX)          ? ctrl_image :
    (req.index == DATA_INDEX)          ? nvm_data_reg :
    (req.index == ADDR_INDEX)          ? nvm_addr_reg :
    (req.index == IRQ_STATUS_INDEX)    ? {6'h00, irq_status} :
    (req.index == IRQ_MASK_INDEX)      ? {6'h00, irq_mask} :
                                         BYTE_ZERO;

  // ==========================================================
  // Launch conditions
  // allow gates start
  wire logic start_ok = wr_ctrl && wbyte[BIT_WSTART] && program_allow
                        && !write_start && !read_start && !warm;
  wire logic read_ok  = wr_ctrl && wbyte[BIT_RSTART] && !flash_space_select
                        && !wbyte[BIT_FLASH_SEL] && !write_start && !read_start && !warm;
  wire logic abort_ev = warm && write_start;

  wire logic [IRQ_W-1:0] irq_events = {abort_ev, timer_done};
  wire logic [IRQ_W-1:0] next_status =
    (irq_status & ~(rd_stat ? {IRQ_W{1'b1}} : IRQ_RESET)) | irq_events;

  wire logic next_write_start = warm       ? 1'b0 :
                                timer_done ? 1'b0 :
                                start_ok   ? 1'b1 : write_start;
  wire logic next_read_start  = read_ok;
  wire logic next_fault = abort_ev ? 1'b1 : (wr_ctrl ? wbyte[BIT_FAULT] : program_fault);

  // ==========================================================
  // AHB-Lite slave: writes take no wait, reads take one wait cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      req       <= '0;
      hreadyout <= 1'b1;
    end else if (accept) begin
      req       <= '{valid: 1'b1, write: hwrite, mapped: hit_low, index: haddr[13:2]};
      hreadyout <= hwrite;
    end else if (rd_do) begin
      hreadyout <= 1'b1;
    end else if (hreadyout) begin
      req.valid <= 1'b0;
    end
  end

  // Read data registered so that the slave's outputs come from flops
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
      hresp  <= 1'b0;
    end else if (rd_do) begin
      hrdata <= {24'h00_0000, rd_byte};
    end
  end

  // ==========================================================
  // Control register; the space select bits survive a warm clear so
  // software can see which space the cut write was aimed at
  // flash select
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flash_space_select  <= 1'b0;
      config_space_select <= 1'b0;
      row_erase_select    <= 1'b0;
      program_allow       <= 1'b0;
    end else if (warm) begin
      row_erase_select    <= 1'b0;
      program_allow       <= 1'b0;
    end else if (wr_ctrl) begin
      flash_space_select  <= wbyte[BIT_FLASH_SEL];
      config_space_select <= wbyte[BIT_CFG_SEL];
      row_erase_select    <= wbyte[BIT_ROW_ERASE];
      program_allow       <= wbyte[BIT_ALLOW];
    end
  end

  // Set-only start bits and the fault flag
  // software set only
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      write_start   <= 1'b0;
      read_start    <= 1'b0;
      program_fault <= 1'b0;
    end else begin
      write_start   <= next_write_start;
      read_start    <= next_read_start;
      program_fault <= next_fault;
    end
  end

  // ==========================================================
  // Data and address registers; the read result lands in data
  // cleared on reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      nvm_data_reg <= BYTE_ZERO;
      nvm_addr_reg <= BYTE_ZERO;
    end else if (warm) begin
      nvm_data_reg <= BYTE_ZERO;
      nvm_addr_reg <= BYTE_ZERO;
    end else begin
      if (read_start) begin
        nvm_data_reg <= nvm_read_data;
      end else if (wr_data) begin
        nvm_data_reg <= wbyte;
      end
      if (wr_addr) begin
        nvm_addr_reg <= wbyte;
      end
    end
  end

  // ==========================================================
  // Command to the storage array; read and write are one-cycle pulses
  // erase select
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      nvm_cmd <= '0;
    end else begin
      nvm_cmd.read  <= read_ok;
      nvm_cmd.write <= start_ok;
      if (start_ok || read_ok) begin
        nvm_cmd.space   <= target_space(flash_space_select, config_space_select);
        nvm_cmd.erase   <= start_ok && row_erase_select
                           && (target_space(flash_space_select, config_space_select)
                               == SPACE_FLASH);
        nvm_cmd.addr    <= nvm_addr_reg;
        nvm_cmd.data    <= nvm_data_reg;
        nvm_cmd.tbl_ptr <= table_pointer;
      end
    end
  end

  // Self-timed write or erase; a warm clear cuts it short
  nvm_op_timer u_timer (
    .hclk    (hclk),
    .hresetn (hresetn),
    .start   (start_ok),
    .abort   (warm),
    .busy    (timer_busy),
    .done    (timer_done)
  );

  // ==========================================================
  // Interrupt status clears on read, events win the same cycle
  // done flag sticky
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_status <= IRQ_RESET;
      irq_mask   <= IRQ_RESET;
      nvm_irq    <= 1'b0;
    end else begin
      irq_status <= next_status;
      irq_mask   <= wr_mask ? wbyte[IRQ_W-1:0] : irq_mask;
      nvm_irq    <= |(next_status & (wr_mask ? wbyte[IRQ_W-1:0] : irq_mask));
    end
  end

  // Busy mirrors the write-start flop
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      nvm_busy <= 1'b0;
    end else begin
      nvm_busy <= next_write_start;
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_write_launch;
    start_ok ##1 nvm_cmd.write;
  endsequence

  a_unlock_reads_zero: assert property (
    (rd_do && req.mapped && req.index == UNLOCK_INDEX) |=> (hrdata == 32'h0000_0000))
    else $error("unlock port read returned nonzero data");

  a_unlock_no_effect: assert property (
    (wr_unlk && !warm && !timer_done && !read_start) |=> $stable(ctrl_image))
    else $error("unlock port write changed control state");

  a_flash_target: assert property (
    (start_ok && flash_space_select && !config_space_select)
      |=> (nvm_cmd.space == SPACE_FLASH))
    else $error("flash select did not target program flash");

  a_config_target: assert property (
    (start_ok && config_space_select) |=> (nvm_cmd.write && nvm_cmd.space == SPACE_CONFIG))
    else $error("config select did not win over flash select");

  a_erase_select: assert property (
    start_ok |=> (nvm_cmd.erase == $past(row_erase_select && flash_space_select
                                         && !config_space_select)))
    else $error("erase command does not follow row erase select");

  a_allow_gate: assert property (
    (wr_ctrl && wbyte[BIT_WSTART] && !program_allow) |=> !nvm_cmd.write)
    else $error("write launched while write allow was clear");

  a_fault_on_abort: assert property (
    (warm && write_start) |=> (program_fault && !write_start && irq_status[IRQ_FAULT]))
    else $error("cut write did not raise the fault bit");

  a_regs_cleared: assert property (
    warm |=> (nvm_data_reg == BYTE_ZERO && nvm_addr_reg == BYTE_ZERO))
    else $error("data or address register not cleared by reset");

  a_start_holds: assert property (
    disable iff (!hresetn || warm) s_write_launch |-> (write_start && timer_busy) [*8])
    else $error("write start dropped before the timed write ended");

  a_done_flag: assert property (
    (timer_done && !warm) |=> (irq_status[IRQ_DONE] && !write_start))
    else $error("completion did not set the done flag");

  a_read_one_cycle: assert property (
    (read_start && !warm) |=> (!read_start && nvm_data_reg == $past(nvm_read_data)))
    else $error("read start not a one cycle read");

  a_reserved_zero: assert property (
    (rd_do && req.mapped && req.index == CTRL_INDEX)
      |=> (hrdata[31:8] == 24'h00_0000 && hrdata[5] == 1'b0))
    else $error("unimplemented control bit read as one");

  a_allow_after_reset: assert property (
    $rose(hresetn) |-> (!program_allow && !write_start && !nvm_busy))
    else $error("write allow or write start set after power-up");

  a_regs_after_reset: assert property (
    $rose(hresetn) |-> (nvm_data_reg == BYTE_ZERO && nvm_addr_reg == BYTE_ZERO))
    else $error("data or address register not zero after power-up");

  a_read_refused: assert property (
    (wr_ctrl && wbyte[BIT_RSTART] && (flash_space_select || wbyte[BIT_FLASH_SEL]))
      |=> (!read_start && !nvm_cmd.read))
    else $error("read started while program flash was selected");

  a_start_set_only: assert property (
    (write_start && !timer_done && !warm) |=> write_start)
    else $error("write start cleared before the timed write ended");

  a_done_sticky: assert property (
    (irq_status[IRQ_DONE] && !rd_stat) |=> irq_status[IRQ_DONE])
    else $error("done flag dropped without a status read");

  // A read that meets a new event keeps that event, so only quiet reads must clear
  sequence s_quiet_status_read;
    rd_stat && (irq_events == IRQ_RESET);
  endsequence

  a_status_read_clears: assert property (
    s_quiet_status_read |=> (irq_status == IRQ_RESET))
    else $error("status read did not clear the flags");

  a_irq_level: assert property (
    nvm_irq == |(irq_status & irq_mask))
    else $error("interrupt output does not follow masked status");

endmodule : nvm_access_control
`default_nettype wire

// [bench/nvm_access_control_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module nvm_access_control_tb_top
  import nvm_pkg::*;
();
  logic        hclk, hresetn, hsel, hwrite, master_clear_pin_n, watchdog_timeout;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [21:0] table_pointer;
  logic [7:0]  nvm_read_data;
  logic        hreadyout, hresp, nvm_busy, nvm_irq;
  nvm_cmd_t    nvm_cmd;
  int          errors, samples_checked;

  // Single slave, so its ready is the bus ready
  nvm_access_control u_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .master_clear_pin_n(master_clear_pin_n), .watchdog_timeout(watchdog_timeout),
    .table_pointer(table_pointer), .nvm_read_data(nvm_read_data),
    .nvm_cmd(nvm_cmd), .nvm_busy(nvm_busy), .nvm_irq(nvm_irq));

  // ==========================================================
  // Clock and run limit
  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end

  // Cuts a hang short well before the run grows long
  initial begin
    repeat (50000) @(posedge hclk);
    timeout("run");
  end

  // ==========================================================
  // Shared tasks
  task automatic print_verdict();
    $display("Checks made: %0d, mismatches: %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : print_verdict

  task automatic timeout(input string what);
    errors++;
    $display("Error at %0t ns: %s wait ran out", $time, what);
    print_verdict();
  endtask : timeout

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t ns: %s got %0h expected %0h", $time, what, got, exp);
    end
  endtask : check

  // Samples hready at each rising edge; never assumes a latency
  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (hreadyout !== 1'b1) timeout("bus");
  endtask : wait_ready

  task automatic bus_write(input logic [11:0] idx, input logic [7:0] val);
    haddr  <= {18'h0, idx, 2'h0};
    htrans <= 2'h2;
    hwrite <= 1'b1;
    wait_ready();
    htrans <= 2'h0;
    hwdata <= {24'h0, val};
    wait_ready();
  endtask : bus_write

  task automatic bus_read(input logic [11:0] idx, output logic [7:0] val);
    haddr  <= {18'h0, idx, 2'h0};
    htrans <= 2'h2;
    hwrite <= 1'b0;
    wait_ready();
    htrans <= 2'h0;
    wait_ready();
    val = hrdata[7:0];
    check(hrdata[31:8], 32'h0, "upper read bits");
    check(hresp, 1'b0, "okay response");
  endtask : bus_read

  // Looks four edges for a read or write pulse on the command port
  task automatic wait_cmd(input bit rd, output nvm_cmd_t c, output bit seen);
    seen = 1'b0;
    c = '0;
    repeat (4) begin
      @(posedge hclk);
      if (!seen && (rd ? nvm_cmd.read : nvm_cmd.write) === 1'b1) begin
        seen = 1'b1;
        c = nvm_cmd;
      end
    end
  endtask : wait_cmd

  task automatic wait_idle(output int n);
    n = 0;
    while (nvm_busy === 1'b1 && n < 400) begin
      @(posedge hclk);
      n++;
    end
    if (n >= 400) timeout("busy");
  endtask : wait_idle

  // Allow must be stored before the launching write
  task automatic launch(input logic [7:0] ctrl);
    bus_write(CTRL_INDEX, (ctrl & 8'hFD) | 8'h04);
    bus_write(CTRL_INDEX, ctrl | 8'h04);
  endtask : launch

  // ==========================================================
  // Scenarios
  task automatic t_reset();
    logic [7:0] d;
    nvm_cmd_t   c;
    bit         seen;
    bus_read(CTRL_INDEX, d);
    check(d, 8'h00, "control after reset");
    bus_read(DATA_INDEX, d);
    check(d, 8'h00, "data after reset");
    bus_read(ADDR_INDEX, d);
    check(d, 8'h00, "address after reset");
    bus_write(UNLOCK_INDEX, 8'hFF);
    bus_read(UNLOCK_INDEX, d);
    check(d, 8'h00, "unlock port read");
    bus_read(12'hFB0, d);
    check(d, 8'h00, "unmapped read");
    // Every bit written while allow was still clear
    bus_write(CTRL_INDEX, 8'hFF);
    wait_cmd(1'b0, c, seen);
    check(seen, 1'b0, "write without allow");
    check(nvm_busy, 1'b0, "busy without allow");
    bus_read(CTRL_INDEX, d);
    check(d, 8'hDC, "control readback");
    bus_write(CTRL_INDEX, 8'h00);
    $display("reset and unlock test done");
  endtask : t_reset

  task automatic t_write();
    logic [7:0] d;
    nvm_cmd_t   c;
    bit         seen;
    int         n;
    bus_write(DATA_INDEX, 8'h5A);
    bus_write(ADDR_INDEX, 8'h33);
    bus_write(IRQ_MASK_INDEX, 8'h00);
    launch(8'h06);
    wait_cmd(1'b0, c, seen);
    check(seen, 1'b1, "write pulse");
    check(c.data, 8'h5A, "write data");
    check(c.addr, 8'h33, "write address");
    check(c.space, SPACE_EEPROM, "eeprom target");
    check(c.erase, 1'b0, "plain write");
    // Software tries to clear write-start mid-operation
    bus_write(CTRL_INDEX, 8'h04);
    bus_read(CTRL_INDEX, d);
    check(d & 8'h02, 8'h02, "write start held");
    wait_idle(n);
    check(n > 180 && n < 205, 1'b1, "operation length");
    bus_read(CTRL_INDEX, d);
    check(d & 8'h02, 8'h00, "write start cleared");
    check(nvm_irq, 1'b0, "masked interrupt");
    bus_write(IRQ_MASK_INDEX, 8'h01);
    repeat (2) @(posedge hclk);
    check(nvm_irq, 1'b1, "unmasked interrupt");
    bus_read(IRQ_STATUS_INDEX, d);
    check(d, 8'h01, "done flag sticky");
    repeat (2) @(posedge hclk);
    check(nvm_irq, 1'b0, "interrupt after clear");
    $display("write test done");
  endtask : t_write

  task automatic t_space();
    nvm_cmd_t c;
    bit       seen, fl, cf;
    space_t   sp;
    int       n;
    for (int i = 0; i < 4; i++) begin
      fl = i[1];
      cf = i[0];
      sp = cf ? SPACE_CONFIG : (fl ? SPACE_FLASH : SPACE_EEPROM);
      table_pointer <= {20'hABCDE, i[1:0]};
      launch({fl, cf, 6'h16});
      wait_cmd(1'b0, c, seen);
      check(seen, 1'b1, "launch per space");
      check(c.space, sp, "target space");
      check(c.erase, fl & ~cf, "row erase");
      check(c.tbl_ptr, {20'hABCDE, i[1:0]}, "erase row pointer");
      wait_idle(n);
    end
    $display("space select test done");
  endtask : t_space

  task automatic t_warm();
    logic [7:0] d;
    for (int k = 0; k < 2; k++) begin
      bus_write(DATA_INDEX, 8'h77);
      bus_write(ADDR_INDEX, 8'h11);
      launch(8'h06);
      repeat (10) @(posedge hclk);
      if (k == 0) watchdog_timeout <= 1'b1;
      else master_clear_pin_n <= 1'b0;
      @(posedge hclk);
      watchdog_timeout   <= 1'b0;
      master_clear_pin_n <= 1'b1;
      @(posedge hclk);
      check(nvm_busy, 1'b0, "busy after warm reset");
      bus_read(CTRL_INDEX, d);
      check(d, 8'h08, "fault after cut write");
      bus_read(DATA_INDEX, d);
      check(d, 8'h00, "data after warm reset");
      bus_read(ADDR_INDEX, d);
      check(d, 8'h00, "address after warm reset");
      bus_read(IRQ_STATUS_INDEX, d);
      check(d & 8'h02, 8'h02, "fault event");
      bus_write(CTRL_INDEX, 8'h00);
    end
    $display("warm reset test done");
  endtask : t_warm

  task automatic t_read();
    logic [7:0] d;
    nvm_cmd_t   c;
    bit         seen;
    nvm_read_data <= 8'hC3;
    bus_write(CTRL_INDEX, 8'h01);
    wait_cmd(1'b1, c, seen);
    check(seen, 1'b1, "eeprom read pulse");
    bus_read(DATA_INDEX, d);
    check(d, 8'hC3, "read data captured");
    bus_read(CTRL_INDEX, d);
    check(d & 8'h01, 8'h00, "read start cleared");
    // Flash selected in the same byte refuses the read
    nvm_read_data <= 8'h3C;
    bus_write(CTRL_INDEX, 8'h81);
    wait_cmd(1'b1, c, seen);
    check(seen, 1'b0, "read refused");
    bus_read(DATA_INDEX, d);
    check(d, 8'hC3, "data unchanged");
    $display("read test done");
  endtask : t_read

  // Mid-run power-on reset; released and first used like the opening one
  task automatic t_power();
    logic [7:0] d;
    nvm_cmd_t   c;
    bit         seen;
    bus_write(DATA_INDEX, 8'h9C);
    bus_write(ADDR_INDEX, 8'h4B);
    bus_write(CTRL_INDEX, 8'h8C);
    hresetn <= 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    bus_read(CTRL_INDEX, d);
    check(d, 8'h00, "control after power-up");
    bus_read(DATA_INDEX, d);
    check(d, 8'h00, "data after power-up");
    bus_read(ADDR_INDEX, d);
    check(d, 8'h00, "address after power-up");
    bus_write(CTRL_INDEX, 8'h02);
    wait_cmd(1'b0, c, seen);
    check(seen, 1'b0, "write refused after power-up");
    check(nvm_busy, 1'b0, "busy after power-up");
    $display("power-on reset test done");
  endtask : t_power

  // ==========================================================
  // Main sequence
  initial begin
    errors = 0;
    samples_checked = 0;
    hresetn = 1'b0;
    hsel = 1'b1;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    master_clear_pin_n = 1'b1;
    watchdog_timeout = 1'b0;
    table_pointer = 22'h0;
    nvm_read_data = 8'h00;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset();
    t_write();
    t_space();
    t_warm();
    t_read();
    t_power();
    print_verdict();
  end
endmodule : nvm_access_control_tb_top
`default_nettype wire
